// ===== common/ofr_pkg.sv
// constants for the over-temperature fault response block
// assumes a single 40 MHz system clock and a command-code register port
package ofr_pkg;

  // ****************************************
  // register command codes
  // ****************************************
  localparam logic [7:0]  OFR_ADDR_LIMIT   = 8'h4F;
  localparam logic [7:0]  OFR_ADDR_ACTION  = 8'h50;

  // ****************************************
  // reset values and minimum delay unit length
  // ****************************************
  localparam logic [15:0] OFR_LIMIT_RST    = 16'h7FFF;
  localparam logic [7:0]  OFR_ACTION_RST   = 8'h80;
  localparam logic [15:0] OFR_UNIT_MIN     = 16'h0001;

  // ****************************************
  // action field layout
  // ****************************************
  localparam int          OFR_RESP_HI      = 7;
  localparam int          OFR_RESP_LO      = 6;
  localparam int          OFR_RETRY_HI     = 5;
  localparam int          OFR_RETRY_LO     = 3;
  localparam int          OFR_DELAY_HI     = 2;
  localparam int          OFR_DELAY_LO     = 0;

  localparam logic [1:0]  OFR_RESP_IGNORE  = 2'h0;
  localparam logic [1:0]  OFR_RESP_DELAY   = 2'h1;
  localparam logic [1:0]  OFR_RESP_RETRY   = 2'h2;
  localparam logic [1:0]  OFR_RESP_LATCH   = 2'h3;
  localparam logic [2:0]  OFR_RETRY_NONE   = 3'h0;
  localparam logic [2:0]  OFR_RETRY_FOREVER = 3'h7;

  // ****************************************
  // timing
  // ****************************************
  localparam int          OFR_CLK_PERIOD_NS  = 25;
  localparam int          OFR_TICK_PERIOD_NS = 100000;
  localparam int          OFR_TICK_CYCLES    =
    (OFR_TICK_PERIOD_NS + OFR_CLK_PERIOD_NS - 1) / OFR_CLK_PERIOD_NS;

  // ****************************************
  // fault handling states
  // ****************************************
  typedef enum logic [3:0] {
    OFR_ST_RUN   = 4'b0001,
    OFR_ST_DELAY = 4'b0010,
    OFR_ST_WAIT  = 4'b0100,
    OFR_ST_LATCH = 4'b1000
  } ofr_state_t;

endpackage

// ===== rtl/ofr_delay_timer.sv
// binary-weighted delay timer: 2**code units, each unit_len ticks long, or one tick when unit_len is zero
// assumes tick is a one-cycle enable from a divider on the same clock
`timescale 1ns/1ps
module ofr_delay_timer
  import ofr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic        tick,
  input  wire logic [15:0] unit_len,
  input  wire logic [2:0]  code,
  output logic             done_q
);

  logic        busy_q;
  logic        busy_d;
  logic        done_d;
  logic [15:0] tick_cnt_q;
  logic [15:0] tick_cnt_d;
  logic [7:0]  unit_cnt_q;
  logic [7:0]  unit_cnt_d;
  logic [8:0]  target_q;
  logic [8:0]  target_d;
  logic [15:0] unit_eff;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    busy_d     = busy_q;
    done_d     = 1'b0;
    tick_cnt_d = tick_cnt_q;
    unit_cnt_d = unit_cnt_q;
    target_d   = target_q;
    unit_eff   = (unit_len == 16'h0000) ? OFR_UNIT_MIN : unit_len;
    if (start) begin
      busy_d     = 1'b1;
      tick_cnt_d = 16'h0000;
      unit_cnt_d = 8'h00;
      target_d   = 9'h001 << code; // see [RULE12]
    end else if (busy_q && tick) begin
      if (tick_cnt_q + 16'h0001 >= unit_eff) begin // see [RULE13]
        tick_cnt_d = 16'h0000;
        unit_cnt_d = unit_cnt_q + 8'h01;
        if ({1'b0, unit_cnt_q} + 9'h001 == target_q) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end else begin
        tick_cnt_d = tick_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      tick_cnt_q <= 16'h0000;
      unit_cnt_q <= 8'h00;
      target_q   <= 9'h001;
    end else begin
      busy_q     <= busy_d;
      done_q     <= done_d;
      tick_cnt_q <= tick_cnt_d;
      unit_cnt_q <= unit_cnt_d;
      target_q   <= target_d;
    end
  end

endmodule // ofr_delay_timer

// ===== rtl/ofr_over_temp_fault.sv
// over-temperature fault limit, action setting and response sequencer
// assumes temp_value and the command port run on clk_sys; ctrl_pin is async
//
// Summary of operation
// [RULE1] sixteen-bit fault threshold register, host writable, linear format
// [RULE2] fault flagged when temperature is at or above the threshold
// [RULE3] response 00: keep running, ignore the fault
// [RULE4] response 01: run for the delay, then retry if fault persists
// [RULE5] response 10: disable output at once, then follow retry count
// [RULE6] response 11: stay disabled until the fault is cleared
// [RULE7] commanding output off then on also clears a latched fault
// [RULE8] retry code 000: no restart, stay off until cleared
// [RULE9] retry codes 001..110: one to six restarts, then stay off
// [RULE10] restart spacing equals delay count times the delay unit
// [RULE11] retry code 111: restart forever until commanded off
// [RULE12] delay code n selects two to the n time units
// [RULE13] unit length comes from the separate time-base register
`timescale 1ns/1ps
module ofr_over_temp_fault
  import ofr_pkg::*;
#(
  parameter int TICK_CYCLES = OFR_TICK_CYCLES
)
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic [15:0] temp_value,
  input  wire logic [15:0] time_unit,
  input  wire logic        ctrl_pin,
  input  wire logic        operation_on,
  input  wire logic        clear_faults,
  input  wire logic        clear_status,
  output logic [15:0]      rd_data_q,
  output logic             rd_valid_q,
  output logic             out_enable_q,
  output logic             ot_fault_q,
  output logic             latched_off_q
);

  // ****************************************
  // declarations
  // ****************************************
  logic [15:0] limit_q;
  logic [15:0] limit_d;
  logic [7:0]  action_q;
  logic [7:0]  action_d;
  logic [15:0] rd_data_d;
  logic        rd_valid_d;
  logic        ctrl_s1_q;
  logic        ctrl_s2_q;
  logic [11:0] div_q;
  logic [11:0] div_d;
  logic        tick_q;
  logic        tick_d;
  ofr_state_t  state_q;
  ofr_state_t  state_d;
  logic [2:0]  tries_q;
  logic [2:0]  tries_d;
  logic        on_prev_q;
  logic        ot_fault_d;
  logic        out_enable_d;
  logic        latched_off_d;
  logic        timer_start;
  logic        timer_done;
  logic        fault;
  logic        on_cmd;
  logic        restart_on;
  logic [1:0]  resp;
  logic [2:0]  retry;

  // ****************************************
  // register port
  // ****************************************
  always_comb begin
    limit_d    = limit_q;
    action_d   = action_q;
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    if (cmd_valid && cmd_write) begin
      if (cmd_code == OFR_ADDR_LIMIT) begin
        limit_d = cmd_wdata; // see [RULE1]
      end
      if (cmd_code == OFR_ADDR_ACTION) begin
        action_d = cmd_wdata[7:0];
      end
    end else if (cmd_valid) begin
      rd_valid_d = 1'b1;
      case (cmd_code)
        OFR_ADDR_LIMIT:  rd_data_d = limit_q;
        OFR_ADDR_ACTION: rd_data_d = {8'h00, action_q};
        default:         rd_data_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      limit_q    <= OFR_LIMIT_RST;
      action_q   <= OFR_ACTION_RST;
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      limit_q    <= limit_d;
      action_q   <= action_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // ****************************************
  // pin synchroniser and time-base divider
  // ****************************************
  always_comb begin
    if (div_q == 12'(TICK_CYCLES - 1)) begin
      div_d  = 12'h000;
      tick_d = 1'b1;
    end else begin
      div_d  = div_q + 12'h001;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_s1_q <= 1'b0;
      ctrl_s2_q <= 1'b0;
      div_q     <= 12'h000;
      tick_q    <= 1'b0;
    end else begin
      ctrl_s1_q <= ctrl_pin;
      ctrl_s2_q <= ctrl_s1_q;
      div_q     <= div_d;
      tick_q    <= tick_d;
    end
  end

  ofr_delay_timer u_timer (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .start    (timer_start),
    .tick     (tick_q),
    .unit_len (time_unit),
    .code     (action_q[OFR_DELAY_HI:OFR_DELAY_LO]),
    .done_q   (timer_done)
  );

  // ****************************************
  // fault response sequencer
  // ****************************************
  always_comb begin
    resp  = action_q[OFR_RESP_HI:OFR_RESP_LO];
    retry = action_q[OFR_RETRY_HI:OFR_RETRY_LO];
    fault = $signed(temp_value) >= $signed(limit_q); // see [RULE2]
    on_cmd      = ctrl_s2_q & operation_on;
    restart_on  = on_cmd & ~on_prev_q;
    state_d     = state_q;
    tries_d     = tries_q;
    timer_start = 1'b0;
    // set wins over clear
    ot_fault_d  = fault | (ot_fault_q & ~(clear_status | clear_faults));
    case (state_q)
      OFR_ST_RUN: begin
        if (fault) begin
          case (resp)
            OFR_RESP_IGNORE: state_d = OFR_ST_RUN; // see [RULE3]
            OFR_RESP_DELAY: begin
              timer_start = 1'b1; // see [RULE4]
              state_d     = OFR_ST_DELAY;
            end
            OFR_RESP_RETRY: state_d = OFR_ST_WAIT; // see [RULE5]
            default:        state_d = OFR_ST_LATCH; // see [RULE6]
          endcase
        end
      end
      OFR_ST_DELAY: begin
        if (timer_done) begin
          state_d = fault ? OFR_ST_WAIT : OFR_ST_RUN; // see [RULE4]
        end
      end
      OFR_ST_WAIT: begin
        if (timer_done) begin
          state_d = OFR_ST_RUN; // see [RULE10]
        end
      end
      OFR_ST_LATCH: begin
        if (clear_status) begin
          state_d = OFR_ST_RUN; // see [RULE6]
          tries_d = 3'h0;
        end
      end
      default: state_d = OFR_ST_RUN;
    endcase
    // entering the off-and-retry path decides restart or latch-off
    if (state_d == OFR_ST_WAIT && state_q != OFR_ST_WAIT) begin
      if (retry == OFR_RETRY_NONE) begin
        state_d = OFR_ST_LATCH; // see [RULE8]
      end else if (retry != OFR_RETRY_FOREVER && tries_q >= retry) begin
        state_d = OFR_ST_LATCH; // see [RULE9]
      end else begin
        timer_start = 1'b1; // see [RULE10]
        if (retry != OFR_RETRY_FOREVER) begin
          tries_d = tries_q + 3'h1; // see [RULE9]
        end // else unlimited, see [RULE11]
      end
    end
    if (clear_faults || restart_on) begin
      state_d = OFR_ST_RUN; // see [RULE6] and [RULE7]
      tries_d = 3'h0;
    end
    out_enable_d  = on_cmd & ((state_d == OFR_ST_RUN) ||
                              (state_d == OFR_ST_DELAY)); // see [RULE11]
    latched_off_d = (state_d == OFR_ST_LATCH);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q       <= OFR_ST_RUN;
      tries_q       <= 3'h0;
      on_prev_q     <= 1'b0;
      ot_fault_q    <= 1'b0;
      out_enable_q  <= 1'b0;
      latched_off_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      tries_q       <= tries_d;
      on_prev_q     <= on_cmd;
      ot_fault_q    <= ot_fault_d;
      out_enable_q  <= out_enable_d;
      latched_off_q <= latched_off_d;
    end
  end

endmodule // ofr_over_temp_fault

// ===== verif/ofr_checker.sv
// port assertions for the over-temperature fault block
// assumes one clock domain; bound to every ofr_over_temp_fault
`timescale 1ns/1ps
module ofr_checker
  import ofr_pkg::*;
#(
  parameter int TICK_CYCLES = OFR_TICK_CYCLES
)
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] temp_value,
  input wire logic [15:0] time_unit,
  input wire logic        ctrl_pin,
  input wire logic        operation_on,
  input wire logic        clear_faults,
  input wire logic        clear_status,
  input wire logic [15:0] rd_data_q,
  input wire logic        rd_valid_q,
  input wire logic        out_enable_q,
  input wire logic        ot_fault_q,
  input wire logic        latched_off_q
);
  logic [15:0]     lim_q, lim_d;
  logic [7:0]      act_q, act_d;
  wire logic       wr = cmd_valid && cmd_write;
  wire logic       rd = cmd_valid && !cmd_write;
  wire logic       flt = $signed(temp_value) >= $signed(lim_q);
  wire logic [1:0] resp = act_q[7:6];
  // shadow copies of the two settings
  always_comb begin
    lim_d = (wr && cmd_code == OFR_ADDR_LIMIT) ? cmd_wdata : lim_q;
    act_d = (wr && cmd_code == OFR_ADDR_ACTION) ? cmd_wdata[7:0] : act_q;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lim_q <= OFR_LIMIT_RST;
      act_q <= OFR_ACTION_RST;
    end else begin
      lim_q <= lim_d;
      act_q <= act_d;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  rd_answer_a: assert property (rd |=> rd_valid_q)
    else $error("read not answered");
  rd_limit_a: assert property (
    rd && cmd_code == OFR_ADDR_LIMIT |=> rd_data_q == $past(lim_q))
    else $error("threshold read wrong");
  fault_flag_a: assert property (flt |=> ot_fault_q)
    else $error("fault not flagged");
  ignore_run_a: assert property (
    (resp == 2'h0 && ctrl_pin && operation_on)[*3] ##0 out_enable_q
    |=> out_enable_q)
    else $error("ignored fault stopped output");
  delay_run_a: assert property (
    resp == 2'h1 && flt && !ot_fault_q && out_enable_q
    |=> out_enable_q[*3])
    else $error("delayed response stopped early");
  disable_now_a: assert property (
    resp == 2'h2 && flt && out_enable_q |=> !out_enable_q)
    else $error("output not disabled");
  latch_off_a: assert property (
    resp == 2'h3 && flt && out_enable_q |=> latched_off_q && !out_enable_q)
    else $error("fault not latched off");
  retry_forever_a: assert property (
    resp == 2'h2 && act_q[5:3] == 3'h7 && !latched_off_q
    |=> !latched_off_q)
    else $error("endless retry latched");
endmodule // ofr_checker

bind ofr_over_temp_fault ofr_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) ofr_checker_inst (.*);

// ===== verif/ofr_host_model.sv
// host model issuing register reads and writes on the command port
// assumes calls come from the bench, one access at a time
`timescale 1ns/1ps
module ofr_host_model
(
  input  wire logic        clk_sys,
  input  wire logic [15:0] rd_data_q,
  input  wire logic        rd_valid_q,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end
  task automatic acc(input logic w, input logic [7:0] c,
                     input logic [15:0] d, output logic [15:0] q,
                     output logic v);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;
    cmd_wdata <= ~d;
    @(negedge clk_sys);
    q = rd_data_q;
    v = rd_valid_q;
  endtask
endmodule // ofr_host_model

// ===== verif/ofr_over_temp_fault_tb_top.sv
// bench for the over-temperature fault block
// assumes package, design, host model and checker compiled first
`timescale 1ns/1ps
module ofr_over_temp_fault_tb_top
  import ofr_pkg::*;
;
  localparam logic [15:0] HOT = 16'h0064;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid, cmd_write, rd_valid_q;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, rd_data_q;
  logic [15:0] temp_value = 16'h0000;
  logic [15:0] time_unit = 16'h0001;
  logic        ctrl_pin = 1'b0;
  logic        operation_on = 1'b0;
  logic        clear_faults = 1'b0;
  logic        clear_status = 1'b0;
  logic        out_enable_q, ot_fault_q, latched_off_q;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  ofr_over_temp_fault #(.TICK_CYCLES(4)) ofr_over_temp_fault_inst (.*);
  ofr_host_model ofr_host_model_inst (.*);
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rw(input logic w, input logic [7:0] c, input logic [15:0] d);
    logic [15:0] q;
    logic        v;
    ofr_host_model_inst.acc(w, c, d, q, v);
    if (!w) begin
      chk("rd_valid", {15'h0000, v}, 16'h0001);
      chk("rd_data", q, d);
    end
  endtask
  task automatic clr(input logic st);
    @(posedge clk_sys);
    temp_value <= 16'h0000;
    clear_status <= st;
    clear_faults <= !st;
    @(posedge clk_sys);
    clear_status <= 1'b0;
    clear_faults <= 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic hot(input int n);
    @(posedge clk_sys);
    temp_value <= HOT;
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic cmd_cycle();
    @(posedge clk_sys) operation_on <= 1'b0;
    repeat (4) @(posedge clk_sys);
    operation_on <= 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int   k, rises, gap, u;
    logic en_prev;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rw(1'b0, OFR_ADDR_LIMIT, OFR_LIMIT_RST);
    rw(1'b0, OFR_ADDR_ACTION, {8'h00, OFR_ACTION_RST});
    rw(1'b0, 8'h33, 16'h0000);
    rw(1'b1, OFR_ADDR_LIMIT, HOT);
    rw(1'b0, OFR_ADDR_LIMIT, HOT);
    @(posedge clk_sys) ctrl_pin <= 1'b1;
    rw(1'b1, OFR_ADDR_ACTION, 16'h0000);
    cmd_cycle();
    hot(20);
    chk("ot_fault", ot_fault_q, 1);
    chk("out_en", out_enable_q, 1);
    rw(1'b1, OFR_ADDR_ACTION, 16'h00C0);
    repeat (3) @(negedge clk_sys);
    chk("latched", latched_off_q, 1);
    clr(1'b1);
    chk("ot_fault", ot_fault_q, 0);
    chk("latched", latched_off_q, 0);
    hot(4);
    chk("latched", latched_off_q, 1);
    @(posedge clk_sys) temp_value <= 16'h0000;
    repeat (4) @(negedge clk_sys);
    chk("latched", latched_off_q, 1);
    cmd_cycle();
    chk("latched", latched_off_q, 0);
    rw(1'b1, OFR_ADDR_ACTION, 16'h0080);
    hot(40);
    chk("out_en", out_enable_q, 0);
    chk("latched", latched_off_q, 1);
    for (int n = 1; n <= 7; n++) begin
      clr(1'b0);
      chk("out_en", out_enable_q, 1);
      u = 4 << (n - 1);
      rw(1'b1, OFR_ADDR_ACTION, 16'(32'h80 | (n << 3) | (n - 1)));
      hot(0);
      en_prev = 1'b1;
      rises = 0;
      gap = 0;
      k = 0;
      while (latched_off_q !== 1'b1 && rises < 8 && k < 3000) begin
        @(negedge clk_sys);
        k++;
        gap++;
        if (out_enable_q === 1'b1 && !en_prev) begin
          if (rises > 0)
            chk("gap", 16'(gap inside {[u-4:u+6]}), 1);
          rises++;
          gap = 0;
        end
        en_prev = out_enable_q;
      end
      chk("restarts", 16'(rises), 16'((n == 7) ? 8 : n));
      chk("latched", latched_off_q, n != 7);
    end
    cmd_cycle();
    clr(1'b0);
    @(posedge clk_sys) time_unit <= 16'h0002;
    rw(1'b1, OFR_ADDR_ACTION, 16'h0047);
    hot(0);
    k = 0;
    while (out_enable_q === 1'b1 && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    chk("delay", 16'(k inside {[1020:1030]}), 1);
    repeat (3) @(negedge clk_sys);
    chk("latched", latched_off_q, 1);
    test_done();
  end
endmodule // ofr_over_temp_fault_tb_top
